/* File: logic/dcffm_pkg.sv */
package dcffm_pkg;

   // ****************************************
   // Widths and depth
   // ****************************************
   localparam int DATA_W = 18;
   localparam int ADDR_W = 15;

   // ****************************************
   // Offset defaults chosen at reset
   // ****************************************
   localparam logic [15:0] OFS_SERIAL_DEFAULT = 16'h03ff;
   localparam logic [15:0] OFS_PARALLEL_DEFAULT = 16'h007f;

   // ****************************************
   // Threshold steps per timing mode
   // ****************************************
   localparam logic [1:0] STEP_STD = 2'h1;
   localparam logic [1:0] STEP_FT = 2'h2;
   localparam logic [1:0] FT_EXTRA = 2'h1;

   // ****************************************
   // Flag bundle, all active low
   // ****************************************
   typedef struct packed {
      logic empty_n;
      logic ready_n;
      logic full_n;
      logic space_n;
      logic almost_empty_n;
      logic almost_full_n;
      logic half_full_n;
   } dcffm_flags_type;

endpackage

/* File: logic/dcffm_top.sv */
// How it works
// R1 - Reset latches timing mode from mode pin
// R2 - Standard timing: empty/full flags, every read requested
// R3 - Fall-through: first word shows after three edges
// R4 - Write on enable low; empty flag rises
// R5 - Standard almost-empty rises at n plus one
// R6 - Standard half-full low at half plus one
// R7 - Standard almost-full low at depth minus m
// R8 - Standard full low at capacity, read clears
// R9 - Writes ignored while full, pointer held
// R10 - Standard almost-empty low at n remaining
// R11 - Read ignored while empty, outputs held
// R12 - Standard empty/full through two register stages
// R13 - Fall-through ready low; almost-empty at n+2
// R14 - Fall-through half-full low at half plus two
// R15 - Fall-through almost-full at depth plus one minus m
// R16 - Fall-through capacity includes output register
// R17 - Fall-through almost-empty low at n+1 remaining
// R18 - Ready three stages, space two stages
// R19 - Load high at reset: serial, offsets 3FF
// R20 - Load low at reset: parallel, offsets 07F
// R21 - Offsets read back in serial and parallel alike
// R22 - Offsets reprogrammable any time after reset
// R23 - Serial shift one bit per edge, LSB first
// R24 - Parallel writes alternate empty then full offset
// R25 - Counts from synchronised pointers against offsets
// R26 - Each side's flags update on its edges
`timescale 1ns/100ps
`default_nettype none

module dcffm_top #(
   parameter int DATA_W = dcffm_pkg::DATA_W,
   parameter int ADDR_W = dcffm_pkg::ADDR_W
) (
   // Clock and master reset
   input wire logic CLK,
   input wire logic RST_B,
   // Strap and control inputs
   input wire logic MODE_PICK_SERIAL_IN,
   input wire logic LOAD_N,
   input wire logic SERIAL_ENABLE_N,
   input wire logic WRITE_EN_N,
   input wire logic READ_EN_N,
   // Data
   input wire logic [DATA_W-1:0] DATA_IN,
   output logic [DATA_W-1:0] DATA_OUT,
   // Status flags
   output logic EMPTY_INDICATOR_N,
   output logic OUTPUT_READY_N,
   output logic FULL_INDICATOR_N,
   output logic INPUT_SPACE_N,
   output logic ALMOST_EMPTY_N,
   output logic ALMOST_FULL_N,
   output logic HALF_FULL_N,
   // Modes latched at reset
   output logic FALL_THROUGH_TIMING,
   output logic SERIAL_LOAD_SELECTED
);

   localparam int CNT_W = ADDR_W + 1;
   localparam int DEPTH = 1 << ADDR_W;
   localparam logic [CNT_W-1:0] DEPTH_C = {1'b1, {ADDR_W{1'b0}}};
   localparam logic [CNT_W-1:0] HALF_C = DEPTH_C >> 1;
   localparam logic [CNT_W-1:0] ONE_C = {{(CNT_W-1){1'b0}}, 1'b1};

   // ****************************************
   // State
   // ****************************************
   logic [DATA_W-1:0] mem [DEPTH];
   logic [CNT_W-1:0] wptr_reg;
   logic [CNT_W-1:0] rptr_reg;
   logic [CNT_W-1:0] wptr_s1_reg;
   logic [CNT_W-1:0] wptr_s2_reg;
   logic [CNT_W-1:0] rptr_s1_reg;
   logic [CNT_W-1:0] rptr_s2_reg;
   logic ov_s1_reg;
   logic ov_s2_reg;
   logic out_valid_reg;
   logic ft_reg;
   logic serial_reg;
   logic [ADDR_W-1:0] empty_ofs_reg;
   logic [ADDR_W-1:0] full_ofs_reg;
   logic ofs_wsel_reg;
   logic ofs_rsel_reg;
   logic [DATA_W-1:0] dout_reg;
   dcffm_pkg::dcffm_flags_type flags;

   // ****************************************
   // Request decode
   // ****************************************
   wire logic wr_req = ~WRITE_EN_N & LOAD_N;
   wire logic rd_req = ~READ_EN_N & LOAD_N;
   wire logic ofs_pwr = ~LOAD_N & ~WRITE_EN_N & ~serial_reg;
   wire logic ofs_ser = ~LOAD_N & ~SERIAL_ENABLE_N & WRITE_EN_N & serial_reg;
   wire logic ofs_rd = ~LOAD_N & ~READ_EN_N;

   // ****************************************
   // Write side view
   // ****************************************
   wire logic [CNT_W-1:0] mem_cnt_w = wptr_reg - rptr_s2_reg;
   wire logic [CNT_W-1:0] wcount = mem_cnt_w + {{(CNT_W-1){1'b0}}, ov_s2_reg};
   wire logic mem_full = (mem_cnt_w == DEPTH_C);
   wire logic wr_take = wr_req & ~mem_full; // R9

   // ****************************************
   // Read side view
   // ****************************************
   wire logic mem_empty = (wptr_s2_reg == rptr_reg);
   wire logic [CNT_W-1:0] rcount = wptr_s2_reg - rptr_reg
      + {{(CNT_W-1){1'b0}}, out_valid_reg};
   wire logic std_take = ~ft_reg & rd_req & ~mem_empty; // R2 R11
   wire logic ft_take = ft_reg & ~mem_empty & (~out_valid_reg | rd_req); // R3
   wire logic rd_take = std_take | ft_take;
   wire logic ft_drain = ft_reg & out_valid_reg & rd_req & mem_empty; // R17

   // ****************************************
   // Thresholds per mode
   // ****************************************
   wire logic [1:0] step = ft_reg ? dcffm_pkg::STEP_FT : dcffm_pkg::STEP_STD;
   wire logic [1:0] extra = ft_reg ? dcffm_pkg::FT_EXTRA : 2'h0;
   wire logic [CNT_W-1:0] step_c = {{(CNT_W-2){1'b0}}, step};
   wire logic [CNT_W-1:0] extra_c = {{(CNT_W-2){1'b0}}, extra};
   wire logic [CNT_W-1:0] pae_lim = {1'b0, empty_ofs_reg} + step_c; // R5 R13
   wire logic [CNT_W-1:0] hf_lim = HALF_C + step_c; // R6 R14
   wire logic [CNT_W-1:0] paf_lim = DEPTH_C - {1'b0, full_ofs_reg} + extra_c; // R7 R15

   // ****************************************
   // Flag assembly
   // ****************************************
   always_comb begin
      flags.empty_n = ft_reg | ~mem_empty; // R12
      flags.ready_n = ~ft_reg | ~out_valid_reg; // R18
      flags.full_n = ft_reg | ~mem_full; // R8 R12
      flags.space_n = ~ft_reg | mem_full; // R16 R18
      flags.almost_empty_n = (rcount >= pae_lim); // R10 R25 R26
      flags.half_full_n = ~(wcount >= hf_lim);
      flags.almost_full_n = ~(wcount >= paf_lim); // R25 R26
   end

   assign EMPTY_INDICATOR_N = flags.empty_n;
   assign OUTPUT_READY_N = flags.ready_n;
   assign FULL_INDICATOR_N = flags.full_n;
   assign INPUT_SPACE_N = flags.space_n;
   assign ALMOST_EMPTY_N = flags.almost_empty_n;
   assign ALMOST_FULL_N = flags.almost_full_n;
   assign HALF_FULL_N = flags.half_full_n;
   assign FALL_THROUGH_TIMING = ft_reg;
   assign SERIAL_LOAD_SELECTED = serial_reg;
   assign DATA_OUT = dout_reg;

   // ****************************************
   // Storage
   // ****************************************
   always_ff @(posedge CLK) begin
      if (wr_take) begin
         mem[wptr_reg[ADDR_W-1:0]] <= DATA_IN; // R4
      end
   end

   // ****************************************
   // Write pointer and crossing stages
   // ****************************************
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         wptr_reg <= '0;
         wptr_s1_reg <= '0;
         wptr_s2_reg <= '0;
         rptr_s1_reg <= '0;
         rptr_s2_reg <= '0;
         ov_s1_reg <= 1'b0;
         ov_s2_reg <= 1'b0;
      end else begin
         if (wr_take) begin
            wptr_reg <= wptr_reg + ONE_C; // R4
         end
         wptr_s1_reg <= wptr_reg; // R12 R18
         wptr_s2_reg <= wptr_s1_reg;
         rptr_s1_reg <= rptr_reg; // R25
         rptr_s2_reg <= rptr_s1_reg;
         ov_s1_reg <= out_valid_reg;
         ov_s2_reg <= ov_s1_reg;
      end
   end

   // ****************************************
   // Read pointer and output register
   // ****************************************
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         rptr_reg <= '0;
         out_valid_reg <= 1'b0;
      end else if (rd_take) begin
         rptr_reg <= rptr_reg + ONE_C;
         out_valid_reg <= ft_reg; // R3
      end else if (ft_drain) begin
         out_valid_reg <= 1'b0; // R17
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         dout_reg <= '0;
      end else if (ofs_rd) begin
         dout_reg <= ofs_rsel_reg ? DATA_W'(full_ofs_reg) : DATA_W'(empty_ofs_reg); // R21
      end else if (rd_take) begin
         dout_reg <= mem[rptr_reg[ADDR_W-1:0]]; // R11
      end
   end

   // ****************************************
   // Modes and offsets
   // ****************************************
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         ft_reg <= MODE_PICK_SERIAL_IN; // R1
         serial_reg <= LOAD_N;
         ofs_wsel_reg <= 1'b0;
         ofs_rsel_reg <= 1'b0;
         if (LOAD_N) begin
            empty_ofs_reg <= ADDR_W'(dcffm_pkg::OFS_SERIAL_DEFAULT); // R19
            full_ofs_reg <= ADDR_W'(dcffm_pkg::OFS_SERIAL_DEFAULT);
         end else begin
            empty_ofs_reg <= ADDR_W'(dcffm_pkg::OFS_PARALLEL_DEFAULT); // R20
            full_ofs_reg <= ADDR_W'(dcffm_pkg::OFS_PARALLEL_DEFAULT);
         end
      end else begin
         if (ofs_ser) begin
            {full_ofs_reg, empty_ofs_reg} <=
               {MODE_PICK_SERIAL_IN, full_ofs_reg, empty_ofs_reg[ADDR_W-1:1]}; // R23 R22
         end else if (ofs_pwr) begin
            ofs_wsel_reg <= ~ofs_wsel_reg; // R24 R22
            if (ofs_wsel_reg) begin
               full_ofs_reg <= DATA_IN[ADDR_W-1:0];
            end else begin
               empty_ofs_reg <= DATA_IN[ADDR_W-1:0];
            end
         end
         if (ofs_rd) begin
            ofs_rsel_reg <= ~ofs_rsel_reg;
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_full_holds_wptr: assert property (@(posedge CLK) disable iff (!RST_B) // R9
      mem_full && wr_req |=> $stable(wptr_reg))
      else $error("write taken while full");

   a_empty_ignores_read: assert property (@(posedge CLK) disable iff (!RST_B) // R11
      !ft_reg && mem_empty && rd_req |=> $stable(rptr_reg) && $stable(dout_reg))
      else $error("read taken while empty");

   a_first_word_falls: assert property (@(posedge CLK) disable iff (!RST_B) // R3
      ft_reg && !out_valid_reg && wr_take && wptr_reg == rptr_reg
      && wptr_s1_reg == rptr_reg && wptr_s2_reg == rptr_reg
      |-> ##3 !out_valid_reg ##1 (out_valid_reg && !OUTPUT_READY_N))
      else $error("first word not shown after three edges");

   a_std_empty_stages: assert property (@(posedge CLK) disable iff (!RST_B) // R12
      !ft_reg && wr_take && wptr_reg == rptr_reg
      && wptr_s1_reg == rptr_reg && wptr_s2_reg == rptr_reg
      |-> !EMPTY_INDICATOR_N [*3] ##1 EMPTY_INDICATOR_N)
      else $error("empty flag timing wrong");

   a_std_pae_mark: assert property (@(posedge CLK) disable iff (!RST_B) // R5
      !ft_reg && rcount == {1'b0, empty_ofs_reg} |-> !ALMOST_EMPTY_N)
      else $error("almost empty high at n words");

   a_ft_pae_mark: assert property (@(posedge CLK) disable iff (!RST_B) // R13
      ft_reg && rcount == {1'b0, empty_ofs_reg} + ONE_C + ONE_C |-> ALMOST_EMPTY_N)
      else $error("almost empty low at n+2 words");

   a_half_full_mark: assert property (@(posedge CLK) disable iff (!RST_B) // R6
      !ft_reg && wcount == HALF_C |-> HALF_FULL_N)
      else $error("half full low too early");

   a_std_paf_mark: assert property (@(posedge CLK) disable iff (!RST_B) // R7
      !ft_reg && wcount == DEPTH_C - {1'b0, full_ofs_reg} |-> !ALMOST_FULL_N)
      else $error("almost full not low at depth minus m");

   a_serial_defaults: assert property (@(posedge CLK) // R19
      !RST_B && LOAD_N |=> empty_ofs_reg == ADDR_W'(dcffm_pkg::OFS_SERIAL_DEFAULT)
      && full_ofs_reg == ADDR_W'(dcffm_pkg::OFS_SERIAL_DEFAULT) && serial_reg)
      else $error("serial defaults wrong");

   a_parallel_defaults: assert property (@(posedge CLK) // R20
      !RST_B && !LOAD_N |=> empty_ofs_reg == ADDR_W'(dcffm_pkg::OFS_PARALLEL_DEFAULT)
      && !serial_reg)
      else $error("parallel defaults wrong");

   a_offset_alternate: assert property (@(posedge CLK) disable iff (!RST_B) // R24
      ofs_pwr && !ofs_wsel_reg |=> empty_ofs_reg == $past(DATA_IN[ADDR_W-1:0]) && ofs_wsel_reg)
      else $error("parallel offset order wrong");

   a_mode_latched: assert property (@(posedge CLK) // R1
      !RST_B |=> FALL_THROUGH_TIMING == $past(MODE_PICK_SERIAL_IN)
      && SERIAL_LOAD_SELECTED == $past(LOAD_N))
      else $error("mode not latched at reset");

   a_std_read_step: assert property (@(posedge CLK) disable iff (!RST_B) // R2
      !ft_reg && rd_req && !mem_empty |=> rptr_reg == $past(rptr_reg) + ONE_C)
      else $error("requested read not taken");

   a_std_pae_rise: assert property (@(posedge CLK) disable iff (!RST_B) // R5 R10
      !ft_reg && rcount == {1'b0, empty_ofs_reg} + ONE_C |-> ALMOST_EMPTY_N)
      else $error("almost empty low at n+1 words");

   a_std_full_flag: assert property (@(posedge CLK) disable iff (!RST_B) // R8
      !ft_reg && wcount == DEPTH_C |-> !FULL_INDICATOR_N)
      else $error("full flag high at capacity");

   a_ft_half_mark: assert property (@(posedge CLK) disable iff (!RST_B) // R14
      ft_reg && wcount == HALF_C + ONE_C |-> HALF_FULL_N)
      else $error("half full low too early");

   a_ft_paf_mark: assert property (@(posedge CLK) disable iff (!RST_B) // R15
      ft_reg && wcount == DEPTH_C - {1'b0, full_ofs_reg} + ONE_C |-> !ALMOST_FULL_N)
      else $error("almost full not low at mark");

   a_ft_space_flag: assert property (@(posedge CLK) disable iff (!RST_B) // R16
      ft_reg && wcount == DEPTH_C + ONE_C |-> INPUT_SPACE_N)
      else $error("input space shown at capacity");

   a_ft_drain_ready: assert property (@(posedge CLK) disable iff (!RST_B) // R17
      ft_drain |=> OUTPUT_READY_N)
      else $error("output ready after last read");

   a_readback_full: assert property (@(posedge CLK) disable iff (!RST_B) // R21
      ofs_rd && ofs_rsel_reg |=> DATA_OUT == DATA_W'($past(full_ofs_reg)))
      else $error("full offset readback wrong");

   a_serial_shift_order: assert property (@(posedge CLK) disable iff (!RST_B) // R23
      ofs_ser |=> full_ofs_reg[ADDR_W-1] == $past(MODE_PICK_SERIAL_IN)
      && empty_ofs_reg[ADDR_W-1] == $past(full_ofs_reg[0]))
      else $error("serial shift order wrong");

endmodule

`default_nettype wire

/* File: sim/dcffm_peer.sv */
`timescale 1ns/100ps
`default_nettype none

module dcffm_peer (
   // Clock
   input wire logic CLK,
   // Requests toward the buffer
   output logic LOAD_N,
   output logic WRITE_EN_N,
   output logic READ_EN_N,
   output logic [17:0] DATA_IN
);

   initial begin
      LOAD_N = 1'b1;
      WRITE_EN_N = 1'b1;
      READ_EN_N = 1'b1;
      DATA_IN = 18'h00000;
   end

   // ****************************************
   // One request held across a single edge
   // ****************************************
   task automatic op(input logic ld, input logic wr, input logic rd, input logic [17:0] d);
      @(negedge CLK);
      LOAD_N = ld;
      WRITE_EN_N = wr;
      READ_EN_N = rd;
      DATA_IN = d;
      @(negedge CLK);
      LOAD_N = 1'b1;
      WRITE_EN_N = 1'b1;
      READ_EN_N = 1'b1;
      // Released bus shows inverse, not stale data
      DATA_IN = ~d;
   endtask

endmodule

`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_top;

   localparam int NOF = 3;
   localparam int DEP = 16;

   logic clk;
   logic rst_b = 1'b0;
   logic mode_pick = 1'b0;
   logic serial_en_n = 1'b1;
   logic [17:0] data_out;
   logic load_n, wen_n, ren_n;
   logic [17:0] din;
   logic ef_n, or_n, ff_n, ir_n, ae_n, af_n, hf_n, fall, serial;
   dcffm_pkg::dcffm_flags_type flags;
   int n_errors = 0;
   int checked = 0;
   int seed = 90434;
   logic [17:0] q[$];
   logic [17:0] d;
   int c;

   assign flags = {ef_n, or_n, ff_n, ir_n, ae_n, af_n, hf_n};

   dcffm_peer peer (.CLK(clk), .LOAD_N(load_n), .WRITE_EN_N(wen_n), .READ_EN_N(ren_n),
      .DATA_IN(din));

   dcffm_top #(.ADDR_W(4)) uut (
      .CLK(clk), .RST_B(rst_b), .MODE_PICK_SERIAL_IN(mode_pick),
      .LOAD_N(load_n), .SERIAL_ENABLE_N(serial_en_n),
      .WRITE_EN_N(wen_n), .READ_EN_N(ren_n),
      .DATA_IN(din), .DATA_OUT(data_out),
      .EMPTY_INDICATOR_N(ef_n), .OUTPUT_READY_N(or_n), .FULL_INDICATOR_N(ff_n),
      .INPUT_SPACE_N(ir_n), .ALMOST_EMPTY_N(ae_n), .ALMOST_FULL_N(af_n),
      .HALF_FULL_N(hf_n), .FALL_THROUGH_TIMING(fall), .SERIAL_LOAD_SELECTED(serial)
   );

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ****************************************
   // Helpers
   // ****************************************
   function automatic dcffm_pkg::dcffm_flags_type want_flags(input int ft, input int c);
      dcffm_pkg::dcffm_flags_type f;
      f.empty_n = (ft != 0) || (c != 0);
      f.ready_n = (ft == 0) || (c == 0);
      f.full_n = (ft != 0) || (c < DEP);
      f.space_n = (ft == 0) || (c > DEP);
      f.almost_empty_n = c >= NOF + 1 + ft;
      f.almost_full_n = c < DEP + ft - NOF;
      f.half_full_n = c < DEP / 2 + 1 + ft;
      return f;
   endfunction

   task automatic check(input logic [17:0] seen, input logic [17:0] want);
      checked++;
      if (seen !== want) begin
         n_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask

   task automatic tally_and_finish();
      if (n_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic do_reset(input int ft, input logic ld);
      @(negedge clk);
      rst_b = 1'b0;
      mode_pick = ft[0];
      peer.LOAD_N = ld;
      repeat (16) @(negedge clk);
      rst_b = 1'b1;
      mode_pick = 1'b0;
      peer.LOAD_N = 1'b1;
      @(negedge clk);
   endtask

   // Eight serial bits, empty offset first
   task automatic shift_offsets(input logic [7:0] bits);
      for (int i = 0; i < 8; i++) begin
         @(negedge clk);
         peer.LOAD_N = 1'b0;
         serial_en_n = 1'b0;
         mode_pick = bits[i];
      end
      @(negedge clk);
      peer.LOAD_N = 1'b1;
      serial_en_n = 1'b1;
      mode_pick = 1'b0;
   endtask

   // ****************************************
   // One pass per timing mode
   // ****************************************
   task automatic run_mode(input int ft);
      logic [17:0] last;
      do_reset(ft, 1'b0);
      check({16'h0000, fall, serial}, {16'h0000, ft[0], 1'b0});
      check(18'(flags), 18'(want_flags(ft, 0)));
      peer.op(1'b0, 1'b0, 1'b1, 18'h00003);
      peer.op(1'b0, 1'b0, 1'b1, 18'h00003);
      peer.op(1'b0, 1'b1, 1'b0, 18'h00000);
      check(data_out, 18'h00003);
      last = data_out;
      peer.op(1'b1, 1'b1, 1'b0, 18'h00000);
      repeat (5) @(negedge clk);
      check(data_out, last);
      d = 18'($random(seed));
      peer.op(1'b1, 1'b0, 1'b1, d);
      check(18'(flags), 18'(want_flags(ft, 0)));
      repeat (4) @(negedge clk);
      check(18'(flags), 18'(want_flags(ft, 1)));
      if (ft != 0) check(data_out, d);
      q.push_back(d);
      c = 1;
      // One extra write beyond capacity must be refused
      while (c < DEP + ft + 1) begin
         d = 18'($random(seed));
         peer.op(1'b1, 1'b0, 1'b1, d);
         if (c < DEP + ft) begin
            q.push_back(d);
            c++;
         end
         repeat (5) @(negedge clk);
         check(18'(flags), 18'(want_flags(ft, c)));
         if (c == DEP + ft) peer.op(1'b1, 1'b0, 1'b1, ~d);
         if (c == DEP + ft) c++;
      end
      c = DEP + ft;
      while (c > 0) begin
         if (ft != 0) check(data_out, q[0]);
         peer.op(1'b1, 1'b1, 1'b0, 18'h00000);
         if (ft == 0) check(data_out, q[0]);
         void'(q.pop_front());
         c--;
         repeat (5) @(negedge clk);
         check(18'(flags), 18'(want_flags(ft, c)));
      end
   endtask

   initial begin
      run_mode(0);
      run_mode(1);
      do_reset(1, 1'b1);
      check({16'h0000, fall, serial}, 18'h00003);
      d = 18'($random(seed));
      shift_offsets(d[7:0]);
      peer.op(1'b0, 1'b1, 1'b0, 18'h00000);
      check(data_out, {14'h0000, d[3:0]});
      peer.op(1'b0, 1'b1, 1'b0, 18'h00000);
      check(data_out, {14'h0000, d[7:4]});
      tally_and_finish();
   end

   initial begin
      #2000000;
      n_errors++;
      tally_and_finish();
   end

endmodule

`default_nettype wire
